// ### rtl/instr_exec_defs.svh
// instr_exec_defs.svh: constants of the bit, transfer and control executor
// assumes: included by its bare name from the package and the executor
`ifndef INSTR_EXEC_DEFS_SVH
`define INSTR_EXEC_DEFS_SVH

// status flag positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// reset values
`define FLAG_RST 8'h00
`define SP_RST 16'h00FF
`define PC_RST 16'h0000

// i/o registers seen through the data space
`define IO_DS_OFS 16'h0020
`define IO_SPACE_N 16'h0040

// register pair index of each pointer
`define PAIR_X 4'hD
`define PAIR_Y 4'hE
`define PAIR_Z 4'hF

// execute cycles per instruction class
`define CYC_BR_NT 2'h1
`define CYC_BR_T 2'h2
`define CYC_IO_BIT 2'h2
`define CYC_SHIFT 2'h1
`define CYC_FLAG 2'h1
`define CYC_MEM 2'h2
`define CYC_STACK 2'h2
`define CYC_CODE_RD 2'h3
`define CYC_SIMPLE 2'h1

`endif

// ### rtl/instr_exec_pkg.sv
// instr_exec_pkg: types shared by the executor and its users
// assumes: the defs header sits beside it
`include "instr_exec_defs.svh"
package instr_exec_pkg;
  // instruction selected by the issuing decoder
  typedef enum logic [5:0] {
    OP_NOP, OP_BR_IRQ_ON, OP_BR_IRQ_OFF, OP_IO_BIT_RAISE, OP_IO_BIT_LOWER,
    OP_SHL_ZERO, OP_SHR_ZERO, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SHR_SIGN,
    OP_NIBBLE_EXCH, OP_FLAG_RAISE, OP_FLAG_LOWER, OP_BIT_TO_T, OP_T_TO_BIT,
    OP_REG_COPY, OP_PAIR_COPY, OP_IMM_LOAD, OP_PTR_READ, OP_PTR_WRITE,
    OP_OFS_READ, OP_OFS_WRITE, OP_DIR_READ, OP_DIR_WRITE, OP_CODE_READ,
    OP_CODE_WRITE, OP_PORT_IN, OP_PORT_OUT, OP_PUSH, OP_POP, OP_SLEEP,
    OP_WDOG, OP_BREAK
  } op_e;
  // pointer access mode
  typedef enum logic [1:0] {AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_IMPLICIT} amode_e;
  // pointer select
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_e;
  // sequencer states, gray along idle-exec-prog
  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_EXEC = 2'h1, S_PW = 2'h3, S_HALT = 2'h2
  } state_e;
endpackage : instr_exec_pkg

// ### rtl/gp_reg_file.sv
// gp_reg_file: working register file, two byte read ports and one pair port
// assumes: all reads registered; one pair-wide write with byte enables
`timescale 1ns/10ps
`default_nettype none
module gp_reg_file #(
  parameter int N = 32
) (
  // clock
  input wire logic core_clk_i,
  // read ports, data one cycle after the address
  input wire logic [4:0] ra_addr_i,
  input wire logic [4:0] rb_addr_i,
  input wire logic [3:0] rp_addr_i,
  output logic [7:0] ra_q_o,
  output logic [7:0] rb_q_o,
  output logic [15:0] rp_q_o,
  // pair write port
  input wire logic [3:0] wp_addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] wbe_i
);
  logic [7:0] mem [N]; // register storage, not reset

  ////////////////////////////////////////////////////////////////////////
  // write lanes then registered reads
  always_ff @(posedge core_clk_i) begin
    for (int g = 0; g < 2; g++) begin
      if (wbe_i[g]) begin
        mem[{wp_addr_i, g[0]}] <= wdata_i[8*g +: 8];
      end
    end
    ra_q_o <= mem[ra_addr_i];
    rb_q_o <= mem[rb_addr_i];
    rp_q_o <= {mem[{rp_addr_i, 1'b1}], mem[{rp_addr_i, 1'b0}]};
  end
endmodule : gp_reg_file
`default_nettype wire

// ### rtl/bit_transfer_instr_exec.sv
// bit_transfer_instr_exec: executes bit, transfer and control instructions
// assumes: a decoder issues one instruction when ready_o is high; data, i/o
// and code memories answer reads in the same cycle as the strobe
// Notes on behaviour
// - interrupt-flag branches take one or two clocks
// - i/o bit raise or lower, two clocks
// - left shifts fill zero or carry, flags
// - right shifts fill zero, carry or sign
// - one flag set or cleared, one clock
// - register bit to and from transfer flag
// - pointer load with post-inc or pre-dec
// - pointer store with same pointer variants
// - displacement access leaves pointer untouched
// - direct address access in two clocks
// - code byte load at pointer, three clocks
// - push and pop take two clocks
// - break only halts for the debugger
// - i/o seen at plus 0x20 in data space
`timescale 1ns/10ps
`default_nettype none
`include "instr_exec_defs.svh"
module bit_transfer_instr_exec import instr_exec_pkg::*; #(
  parameter logic [15:0] SP_RESET = `SP_RST
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // instruction issue
  input wire logic instr_valid_i,
  input wire op_e op_i,
  input wire logic [4:0] rd_i,
  input wire logic [4:0] rr_i,
  input wire logic [2:0] bsel_i,
  input wire ptr_e ptr_i,
  input wire amode_e amode_i,
  input wire logic [15:0] imm_i,
  output logic ready_o,
  output logic done_o,
  // data space
  output logic [15:0] data_addr_o,
  output logic [7:0] data_wdata_o,
  output logic data_re_o,
  output logic data_we_o,
  input wire logic [7:0] data_rdata_i,
  // i/o space
  output logic [5:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic io_re_o,
  output logic io_we_o,
  input wire logic [7:0] io_rdata_i,
  // program memory
  output logic [14:0] code_addr_o,
  output logic [15:0] code_wdata_o,
  output logic code_re_o,
  output logic code_wr_o,
  input wire logic [15:0] code_rdata_i,
  input wire logic pw_done_i,
  // core state and control
  output logic [15:0] pc_o,
  output logic [15:0] sp_o,
  output logic [7:0] status_flags_o,
  output logic sleep_o,
  output logic wdog_o,
  output logic break_o,
  input wire logic resume_i
);
  state_e state_reg, state_next; // sequencer
  logic [1:0] cnt_reg, cnt_next; // execute cycle index
  logic [15:0] pc_reg, pc_next, sp_reg, sp_next;
  logic [7:0] status_flags_reg, status_flags_reg_next;
  logic ready_reg, ready_next, done_reg, done_next, break_reg, break_next;
  logic sleep_reg, sleep_next, wdog_reg, wdog_next;
  // bus output flops
  logic [15:0] data_addr_reg, data_addr_next;
  logic [7:0] data_wdata_reg, data_wdata_next, io_wdata_reg, io_wdata_next;
  logic data_re_reg, data_re_next, data_we_reg, data_we_next;
  logic [5:0] io_addr_reg, io_addr_next;
  logic io_re_reg, io_re_next, io_we_reg, io_we_next;
  logic [14:0] code_addr_reg, code_addr_next;
  logic [15:0] code_wdata_reg, code_wdata_next;
  logic code_re_reg, code_re_next, code_wr_reg, code_wr_next;
  // latched operands
  op_e op_reg, op_next;
  amode_e amode_reg, amode_next;
  logic [4:0] rd_reg, rd_next;
  logic [2:0] bsel_reg, bsel_next;
  logic [15:0] imm_reg, imm_next, addr_reg, addr_next;
  logic [3:0] pair_reg, pair_next;
  logic [7:0] tmp_reg, tmp_next;
  // register file hookup
  logic [7:0] ra_q, rb_q;
  logic [15:0] rp_q, rf_wdata;
  logic [4:0] ra_sel, rb_sel;
  logic [3:0] rp_sel, rf_waddr;
  logic [1:0] rf_wbe;
  // execute helpers
  logic [1:0] need; // cycles of current instruction
  logic last, taken, wr_byte, mem_rd, mem_wr, pw_go, in_io;
  logic [7:0] res, mem_wdata, bit_mask, rdata_sel;
  logic [15:0] eff_addr, io_off, k_ext;
  logic sh_c;

  assign bit_mask = 8'h01 << bsel_reg;
  assign k_ext = {{9{imm_reg[6]}}, imm_reg[6:0]};
  assign rdata_sel = io_re_reg ? io_rdata_i : data_rdata_i;

  ////////////////////////////////////////////////////////////////////////
  // register file read selects, taken at issue
  always_comb begin
    ra_sel = (op_i == OP_CODE_WRITE) ? 5'h00 : rd_i;
    rb_sel = (op_i == OP_CODE_WRITE) ? 5'h01 : rr_i;
    case (ptr_i)
      PTR_X: rp_sel = `PAIR_X;
      PTR_Y: rp_sel = `PAIR_Y;
      default: rp_sel = `PAIR_Z;
    endcase
    if (op_i == OP_PAIR_COPY) begin
      rp_sel = rr_i[4:1];
    end
  end

  gp_reg_file #(.N(32)) u_rf (
    .core_clk_i(core_clk_i),
    .ra_addr_i(ra_sel),
    .rb_addr_i(rb_sel),
    .rp_addr_i(rp_sel),
    .ra_q_o(ra_q),
    .rb_q_o(rb_q),
    .rp_q_o(rp_q),
    .wp_addr_i(rf_waddr),
    .wdata_i(rf_wdata),
    .wbe_i(rf_wbe)
  );

  ////////////////////////////////////////////////////////////////////////
  // next-state logic of the whole executor
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pc_next = pc_reg;
    sp_next = sp_reg;
    status_flags_reg_next = status_flags_reg;
    {op_next, amode_next, rd_next, bsel_next} = {op_reg, amode_reg, rd_reg, bsel_reg};
    {imm_next, addr_next, pair_next, tmp_next} = {imm_reg, addr_reg, pair_reg, tmp_reg};
    {data_addr_next, data_wdata_next} = {data_addr_reg, data_wdata_reg};
    {io_addr_next, io_wdata_next} = {io_addr_reg, io_wdata_reg};
    {code_addr_next, code_wdata_next} = {code_addr_reg, code_wdata_reg};
    {data_re_next, data_we_next, io_re_next, io_we_next} = 4'h0;
    {code_re_next, code_wr_next, done_next, sleep_next, wdog_next} = 5'h00;
    rf_waddr = rd_reg[4:1];
    rf_wdata = rp_q;
    rf_wbe = 2'h0;
    {eff_addr, io_off} = 32'h0;
    {mem_rd, mem_wr, wr_byte, pw_go, in_io, last} = 6'h00;
    mem_wdata = rb_q;
    need = `CYC_SIMPLE;
    res = ra_q;
    sh_c = 1'b0;
    taken = status_flags_reg[`FLAG_I] == (op_reg == OP_BR_IRQ_ON);
    case (state_reg)
      // take a new instruction; i/o bit and port-in reads start now
      S_IDLE: begin
        if (instr_valid_i) begin
          state_next = S_EXEC;
          cnt_next = 2'h0;
          {op_next, amode_next, bsel_next, imm_next} = {op_i, amode_i, bsel_i, imm_i};
          pair_next = rp_sel;
          rd_next = (op_i == OP_CODE_READ && amode_i == AM_IMPLICIT) ? 5'h00 : rd_i;
          if (op_i inside {OP_IO_BIT_RAISE, OP_IO_BIT_LOWER, OP_PORT_IN}) begin
            io_re_next = 1'b1;
            io_addr_next = imm_i[5:0];
          end
        end
      end
      S_EXEC: begin
        cnt_next = cnt_reg + 2'h1;
        if (cnt_reg == 2'h0) begin
          pc_next = pc_reg + ((op_reg inside {OP_DIR_READ, OP_DIR_WRITE}) ? 16'h0002 : 16'h0001);
        end
        case (op_reg)
          // interrupt-flag branches
          OP_BR_IRQ_ON, OP_BR_IRQ_OFF: begin
            need = taken ? `CYC_BR_T : `CYC_BR_NT;
            if (cnt_reg == 2'h0 && taken) begin
              pc_next = pc_reg + k_ext + 16'h0001;
            end
          end
          // read-modify-write of one i/o bit
          OP_IO_BIT_RAISE, OP_IO_BIT_LOWER: begin
            need = `CYC_IO_BIT;
            if (cnt_reg == 2'h0) begin
              io_we_next = 1'b1;
              io_wdata_next = (op_reg == OP_IO_BIT_RAISE) ? (io_rdata_i | bit_mask)
                                                          : (io_rdata_i & ~bit_mask);
            end
          end
          // shifts and rotates; s and h keep their value
          OP_SHL_ZERO, OP_ROT_LEFT, OP_SHR_ZERO, OP_ROT_RIGHT, OP_SHR_SIGN: begin
            need = `CYC_SHIFT;
            wr_byte = 1'b1;
            case (op_reg)
              OP_SHL_ZERO: {sh_c, res} = {ra_q, 1'b0};
              OP_ROT_LEFT: {sh_c, res} = {ra_q, status_flags_reg[`FLAG_C]};
              OP_SHR_ZERO: {res, sh_c} = {1'b0, ra_q};
              OP_ROT_RIGHT: {res, sh_c} = {status_flags_reg[`FLAG_C], ra_q};
              default: {res, sh_c} = {ra_q[7], ra_q};
            endcase
            status_flags_reg_next[`FLAG_C] = sh_c;
            status_flags_reg_next[`FLAG_Z] = (res == 8'h00);
            status_flags_reg_next[`FLAG_N] = res[7];
            status_flags_reg_next[`FLAG_V] = res[7] ^ sh_c;
          end
          OP_NIBBLE_EXCH: begin
            wr_byte = 1'b1;
            res = {ra_q[3:0], ra_q[7:4]};
          end
          // dedicated flag forms arrive as an index
          OP_FLAG_RAISE, OP_FLAG_LOWER: begin
            need = `CYC_FLAG;
            status_flags_reg_next[bsel_reg] = (op_reg == OP_FLAG_RAISE);
          end
          OP_BIT_TO_T: status_flags_reg_next[`FLAG_T] = ra_q[bsel_reg];
          OP_T_TO_BIT: begin
            wr_byte = 1'b1;
            res[bsel_reg] = status_flags_reg[`FLAG_T];
          end
          OP_REG_COPY: {wr_byte, res} = {1'b1, rb_q};
          OP_IMM_LOAD: {wr_byte, res} = {1'b1, imm_reg[7:0]};
          OP_PAIR_COPY: rf_wbe = 2'h3;
          OP_PORT_IN: {wr_byte, res} = {1'b1, io_rdata_i};
          OP_PORT_OUT: begin
            io_we_next = 1'b1;
            io_addr_next = imm_reg[5:0];
            io_wdata_next = rb_q;
          end
          OP_SLEEP: sleep_next = 1'b1;
          OP_WDOG: wdog_next = 1'b1;
          // pointer, displacement and direct data access
          OP_PTR_READ, OP_PTR_WRITE, OP_OFS_READ, OP_OFS_WRITE, OP_DIR_READ, OP_DIR_WRITE: begin
            need = `CYC_MEM;
            if (cnt_reg == 2'h0) begin
              mem_rd = op_reg inside {OP_PTR_READ, OP_OFS_READ, OP_DIR_READ};
              mem_wr = !mem_rd;
              case (op_reg)
                OP_OFS_READ, OP_OFS_WRITE: eff_addr = rp_q + {10'h000, imm_reg[5:0]};
                OP_DIR_READ, OP_DIR_WRITE: eff_addr = imm_reg;
                default: eff_addr = (amode_reg == AM_PREDEC) ? rp_q - 16'h0001 : rp_q;
              endcase
              if (op_reg inside {OP_PTR_READ, OP_PTR_WRITE} && amode_reg inside {AM_POSTINC, AM_PREDEC}) begin
                rf_waddr = pair_reg;
                rf_wbe = 2'h3;
                rf_wdata = (amode_reg == AM_PREDEC) ? rp_q - 16'h0001 : rp_q + 16'h0001;
              end
            end else begin
              wr_byte = op_reg inside {OP_PTR_READ, OP_OFS_READ, OP_DIR_READ};
              res = rdata_sel;
            end
          end
          // stack: push stores then decrements, pop increments then loads
          OP_PUSH, OP_POP: begin
            need = `CYC_STACK;
            if (cnt_reg == 2'h0) begin
              mem_wr = (op_reg == OP_PUSH);
              mem_rd = (op_reg == OP_POP);
              eff_addr = mem_wr ? sp_reg : sp_reg + 16'h0001;
              sp_next = mem_wr ? sp_reg - 16'h0001 : sp_reg + 16'h0001;
            end else begin
              wr_byte = (op_reg == OP_POP);
              res = rdata_sel;
            end
          end
          // code byte read: address, capture, write back
          OP_CODE_READ: begin
            need = `CYC_CODE_RD;
            if (cnt_reg == 2'h0) begin
              code_re_next = 1'b1;
              code_addr_next = rp_q[15:1];
              addr_next = rp_q;
              if (amode_reg == AM_POSTINC) begin
                {rf_waddr, rf_wbe, rf_wdata} = {`PAIR_Z, 2'h3, rp_q + 16'h0001};
              end
            end else if (cnt_reg == 2'h1) begin
              tmp_next = addr_reg[0] ? code_rdata_i[15:8] : code_rdata_i[7:0];
            end else begin
              {wr_byte, res} = {1'b1, tmp_reg};
            end
          end
          OP_CODE_WRITE: begin
            pw_go = 1'b1;
            code_wr_next = 1'b1;
            code_addr_next = rp_q[15:1];
            code_wdata_next = {rb_q, ra_q};
          end
          default: ;
        endcase
        last = (cnt_reg == need - 2'h1);
        if (op_reg == OP_BREAK) begin
          state_next = S_HALT;
        end else if (pw_go) begin
          state_next = S_PW;
        end else if (last) begin
          state_next = S_IDLE;
          done_next = 1'b1;
        end
      end
      // programming logic decides how long the write lasts
      S_PW: begin
        if (pw_done_i) begin
          state_next = S_IDLE;
          done_next = 1'b1;
        end
      end
      S_HALT: begin
        if (resume_i) begin
          state_next = S_IDLE;
          done_next = 1'b1;
        end
      end
      default: state_next = S_IDLE;
    endcase
    // single byte write-back to the destination register
    if (wr_byte) begin
      rf_waddr = rd_reg[4:1];
      rf_wdata = {res, res};
      rf_wbe = rd_reg[0] ? 2'h2 : 2'h1;
    end
    // data space access; the i/o window goes to the i/o port
    io_off = eff_addr - `IO_DS_OFS;
    in_io = (eff_addr >= `IO_DS_OFS) && (io_off < `IO_SPACE_N);
    if (mem_rd || mem_wr) begin
      if (in_io) begin
        {io_re_next, io_we_next, io_addr_next} = {mem_rd, mem_wr, io_off[5:0]};
        io_wdata_next = mem_wdata;
      end else begin
        {data_re_next, data_we_next, data_addr_next} = {mem_rd, mem_wr, eff_addr};
        data_wdata_next = mem_wdata;
      end
    end
    ready_next = (state_next == S_IDLE);
    break_next = (state_next == S_HALT);
  end

  ////////////////////////////////////////////////////////////////////////
  // control and output registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      {state_reg, cnt_reg, pc_reg, sp_reg} <= {S_IDLE, 2'h0, `PC_RST, SP_RESET};
      {status_flags_reg, ready_reg, done_reg, break_reg} <= {`FLAG_RST, 3'h4};
      {sleep_reg, wdog_reg, data_re_reg, data_we_reg} <= 4'h0;
      {io_re_reg, io_we_reg, code_re_reg, code_wr_reg} <= 4'h0;
      {data_addr_reg, data_wdata_reg, io_addr_reg, io_wdata_reg} <= 38'h0;
      {code_addr_reg, code_wdata_reg} <= 31'h0;
    end else begin
      {state_reg, cnt_reg, pc_reg, sp_reg} <= {state_next, cnt_next, pc_next, sp_next};
      {status_flags_reg, ready_reg, done_reg, break_reg} <=
        {status_flags_reg_next, ready_next, done_next, break_next};
      {sleep_reg, wdog_reg, data_re_reg, data_we_reg} <=
        {sleep_next, wdog_next, data_re_next, data_we_next};
      {io_re_reg, io_we_reg, code_re_reg, code_wr_reg} <=
        {io_re_next, io_we_next, code_re_next, code_wr_next};
      {data_addr_reg, data_wdata_reg} <= {data_addr_next, data_wdata_next};
      {io_addr_reg, io_wdata_reg} <= {io_addr_next, io_wdata_next};
      {code_addr_reg, code_wdata_reg} <= {code_addr_next, code_wdata_next};
    end
  end

  // latched operands, data path only
  always_ff @(posedge core_clk_i) begin
    {op_reg, amode_reg, rd_reg, bsel_reg} <= {op_next, amode_next, rd_next, bsel_next};
    {imm_reg, addr_reg, pair_reg, tmp_reg} <= {imm_next, addr_next, pair_next, tmp_next};
  end

  assign {ready_o, done_o, break_o, sleep_o, wdog_o} =
    {ready_reg, done_reg, break_reg, sleep_reg, wdog_reg};
  assign {data_addr_o, data_wdata_o, data_re_o, data_we_o} =
    {data_addr_reg, data_wdata_reg, data_re_reg, data_we_reg};
  assign {io_addr_o, io_wdata_o, io_re_o, io_we_o} =
    {io_addr_reg, io_wdata_reg, io_re_reg, io_we_reg};
  assign {code_addr_o, code_wdata_o, code_re_o, code_wr_o} =
    {code_addr_reg, code_wdata_reg, code_re_reg, code_wr_reg};
  assign {pc_o, sp_o, status_flags_o} = {pc_reg, sp_reg, status_flags_reg};

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  assign acc = instr_valid_i && ready_o;

  property p_br_taken;
    acc && op_i == OP_BR_IRQ_ON && status_flags_o[`FLAG_I] |-> ##1 !done_o ##1 !done_o ##1 done_o;
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch not two clocks");
  property p_br_skip;
    acc && op_i == OP_BR_IRQ_OFF && status_flags_o[`FLAG_I] |-> ##2 done_o && pc_o == $past(pc_o, 2) + 16'h0001;
  endproperty
  a_br_skip: assert property (p_br_skip) else $error("untaken branch wrong");
  property p_io_bit;
    acc && op_i == OP_IO_BIT_RAISE |-> ##1 io_re_o ##1 io_we_o && io_wdata_o[bsel_reg] ##1 done_o;
  endproperty
  a_io_bit: assert property (p_io_bit) else $error("i/o bit raise sequence wrong");
  property p_shl_carry;
    state_reg == S_EXEC && op_reg == OP_SHL_ZERO |=> status_flags_o[`FLAG_C] == $past(ra_q[7]);
  endproperty
  a_shl_carry: assert property (p_shl_carry) else $error("left shift carry wrong");
  property p_rotr_carry;
    state_reg == S_EXEC && op_reg == OP_ROT_RIGHT |=> status_flags_o[`FLAG_C] == $past(ra_q[0]);
  endproperty
  a_rotr_carry: assert property (p_rotr_carry) else $error("rotate right carry wrong");
  property p_flag_raise;
    acc && op_i == OP_FLAG_RAISE |-> ##2 done_o && status_flags_o[$past(bsel_i, 2)];
  endproperty
  a_flag_raise: assert property (p_flag_raise) else $error("flag not raised");
  property p_to_t;
    state_reg == S_EXEC && op_reg == OP_BIT_TO_T |=> status_flags_o[`FLAG_T] == $past(ra_q[bsel_reg]);
  endproperty
  a_to_t: assert property (p_to_t) else $error("transfer flag not copied");
  property p_ptr_rd;
    acc && op_i == OP_PTR_READ |-> ##1 !(data_re_o || io_re_o) ##1 (data_re_o || io_re_o) ##1 done_o;
  endproperty
  a_ptr_rd: assert property (p_ptr_rd) else $error("pointer read timing wrong");
  property p_push;
    acc && op_i == OP_PUSH |-> ##2 (data_we_o || io_we_o) && sp_o == $past(sp_o, 2) - 16'h0001 ##1 done_o;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_code_rd;
    acc && op_i == OP_CODE_READ |-> ##1 !code_re_o ##1 code_re_o ##1 !done_o ##1 done_o;
  endproperty
  a_code_rd: assert property (p_code_rd) else $error("code read not three clocks");
  property p_io_window;
    data_re_o || data_we_o |-> !(data_addr_o >= `IO_DS_OFS && data_addr_o < `IO_DS_OFS + `IO_SPACE_N);
  endproperty
  a_io_window: assert property (p_io_window) else $error("i/o window reached data port");

  c_br_taken: cover property (acc && op_i == OP_BR_IRQ_ON && status_flags_o[`FLAG_I]);
  c_code_post: cover property (acc && op_i == OP_CODE_READ && amode_i == AM_POSTINC);
  c_pw_wait: cover property (state_reg == S_PW [*3] ##1 done_o);
endmodule : bit_transfer_instr_exec
`default_nettype wire

// ### tb/mem_model.sv
// mem_model: data space, i/o registers and program memory beside the executor
// assumes: reads answer in the strobe's cycle; a code write ends after a wait
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  // strobes and addresses from the executor
  input wire logic core_clk_i, data_re_i, data_we_i, io_re_i, io_we_i, code_re_i, code_wr_i,
  input wire logic [15:0] data_addr_i, code_wdata_i,
  input wire logic [7:0] data_wdata_i, io_wdata_i,
  input wire logic [5:0] io_addr_i,
  input wire logic [14:0] code_addr_i,
  // read data and end of a code write
  output logic [7:0] data_rdata_o, io_rdata_o,
  output logic [15:0] code_rdata_o,
  output logic pw_done_o
);
  logic [7:0] dmem [0:511]; // data space
  logic [7:0] iomem [0:63]; // i/o registers
  logic [15:0] cmem [0:255]; // code words
  logic [2:0] wait_cnt = 3'h0; // programming time left
  // known contents for every read
  initial for (int i = 0; i < 512; i++) begin
    dmem[i] = 8'h00;
    iomem[i % 64] = 8'h41;
    cmem[i % 256] = {~i[7:0], i[7:0]};
  end
  // outside a read the lines show the inverse, never a stale copy
  assign data_rdata_o = data_re_i ? dmem[data_addr_i[8:0]] : ~dmem[data_addr_i[8:0]];
  assign io_rdata_o = io_re_i ? iomem[io_addr_i] : ~iomem[io_addr_i];
  assign code_rdata_o = code_re_i ? cmem[code_addr_i[7:0]] : ~cmem[code_addr_i[7:0]];
  assign pw_done_o = (wait_cnt == 3'h1);
  // writes land at the edge; a code write lasts a few cycles
  always @(posedge core_clk_i) begin
    if (data_we_i) dmem[data_addr_i[8:0]] <= data_wdata_i;
    if (io_we_i) iomem[io_addr_i] <= io_wdata_i;
    if (code_wr_i) cmem[code_addr_i[7:0]] <= code_wdata_i;
    wait_cnt <= code_wr_i ? 3'h5 : wait_cnt - 3'(wait_cnt != 3'h0);
  end
endmodule : mem_model
`default_nettype wire

// ### tb/bit_transfer_instr_exec_test.sv
// bit_transfer_instr_exec_test: instruction sequences with expected results
// assumes: mem_model stands in for data, i/o and code memory
`timescale 1ns/10ps
`default_nettype none
module bit_transfer_instr_exec_test import instr_exec_pkg::*; ;
  logic core_clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, resume_i = 1'b0;
  logic ready_o, done_o, data_re_o, data_we_o, io_re_o, io_we_o, code_re_o, code_wr_o;
  logic pw_done_i, sleep_o, wdog_o, break_o;
  op_e op_i = OP_NOP;
  ptr_e ptr_i = PTR_X;
  amode_e amode_i = AM_PLAIN;
  logic [4:0] rd_i = '0, rr_i = '0;
  logic [2:0] bsel_i = '0;
  logic [5:0] io_addr_o;
  logic [14:0] code_addr_o;
  logic [7:0] data_rdata_i, io_rdata_i, data_wdata_o, io_wdata_o, status_flags_o;
  logic [15:0] imm_i = '0, code_rdata_i, code_wdata_o, data_addr_o, pc_o, sp_o, lat, t;
  int num_errors = 0, num_checks = 0;
  // shift cases: operand, carry in, result, flags v n z c
  op_e so[6] = '{OP_SHL_ZERO, OP_ROT_LEFT, OP_SHR_ZERO, OP_ROT_RIGHT, OP_SHR_SIGN, OP_SHL_ZERO};
  logic [31:0] sv[6] = '{32'h8100_0209, 32'h8101_0309, 32'h8101_4009, 32'h0101_8005,
    32'h8000_C00C, 32'h8000_000B};
  always #5 core_clk_i = ~core_clk_i;
  bit_transfer_instr_exec bit_transfer_instr_exec_i (.*);
  mem_model mem_model_i (.core_clk_i, .data_addr_i(data_addr_o), .data_wdata_i(data_wdata_o),
    .data_re_i(data_re_o), .data_we_i(data_we_o), .data_rdata_o(data_rdata_i),
    .io_addr_i(io_addr_o), .io_wdata_i(io_wdata_o), .io_re_i(io_re_o), .io_we_i(io_we_o),
    .io_rdata_o(io_rdata_i), .code_addr_i(code_addr_o), .code_wdata_i(code_wdata_o),
    .code_re_i(code_re_o), .code_wr_i(code_wr_o), .code_rdata_o(code_rdata_i),
    .pw_done_o(pw_done_i));
  // compare and count
  task automatic c(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, want %h", $time, s, e);
    end
  endtask : c
  // issue one instruction, m = pointer and mode; lat gets its execute clocks
  task automatic x(op_e o, logic [4:0] d, r, logic [2:0] s, logic [3:0] m, logic [15:0] q);
    @(negedge core_clk_i);
    {op_i, rd_i, rr_i, bsel_i, imm_i} = {o, d, r, s, q};
    ptr_i = ptr_e'(m[3:2]);
    amode_i = amode_e'(m[1:0]);
    instr_valid_i = 1'b1;
    @(negedge core_clk_i);
    instr_valid_i = 1'b0;
    lat = 16'h0;
    while (done_o !== 1'b1 && lat < 16'h40) begin
      @(posedge core_clk_i);
      #1 lat++;
    end
  endtask : x
  task automatic li(logic [4:0] d, logic [15:0] k);
    x(OP_IMM_LOAD, d, 5'h0, 3'h0, 4'h0, k);
  endtask : li
  task automatic sd(logic [4:0] r, logic [15:0] k);
    x(OP_DIR_WRITE, 5'h0, r, 3'h0, 4'h0, k);
  endtask : sd
  task automatic complete_run;
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // watchdog against a hang
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    c(sp_o, 16'h00FF);
    for (int i = 0; i < 8; i++) begin
      x(OP_FLAG_RAISE, 5'h0, 5'h0, i[2:0], 4'h0, 16'h0);
      c(lat, 16'h1);
    end
    c(status_flags_o, 16'h00FF);
    t = pc_o;
    x(OP_BR_IRQ_ON, 5'h0, 5'h0, 3'h0, 4'h0, 16'h5);
    c(lat, 16'h2);
    c(pc_o, t + 16'h6);
    x(OP_BR_IRQ_OFF, 5'h0, 5'h0, 3'h0, 4'h0, 16'h5);
    c(lat, 16'h1);
    c(pc_o, t + 16'h7);
    for (int i = 0; i < 8; i++) x(OP_FLAG_LOWER, 5'h0, 5'h0, i[2:0], 4'h0, 16'h0);
    c(status_flags_o, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      li(5'h10, {8'h00, sv[i][31:24]});
      x(sv[i][16] ? OP_FLAG_RAISE : OP_FLAG_LOWER, 5'h0, 5'h0, 3'h0, 4'h0, 16'h0);
      x(so[i], 5'h10, 5'h0, 3'h0, 4'h0, 16'h0);
      c(lat, 16'h1);
      c(status_flags_o, {8'h00, sv[i][7:0]});
      sd(5'h10, 16'h0100);
      c(mem_model_i.dmem[256], {8'h00, sv[i][15:8]});
    end
    x(OP_IO_BIT_RAISE, 5'h0, 5'h0, 3'h3, 4'h0, 16'h5);
    c(lat, 16'h2);
    x(OP_IO_BIT_LOWER, 5'h0, 5'h0, 3'h0, 4'h0, 16'h5);
    c({status_flags_o, mem_model_i.iomem[5]}, 16'h0B48);
    x(OP_FLAG_RAISE, 5'h0, 5'h0, 3'h6, 4'h0, 16'h0);
    x(OP_T_TO_BIT, 5'h10, 5'h0, 3'h2, 4'h0, 16'h0);
    x(OP_FLAG_LOWER, 5'h0, 5'h0, 3'h6, 4'h0, 16'h0);
    x(OP_BIT_TO_T, 5'h10, 5'h0, 3'h2, 4'h0, 16'h0);
    c(status_flags_o, 16'h004B);
    li(5'h1A, 16'h0010);
    li(5'h1B, 16'h0001);
    li(5'h11, 16'h003C);
    x(OP_PTR_WRITE, 5'h0, 5'h11, 3'h0, 4'h1, 16'h0);
    c(lat, 16'h2);
    x(OP_PTR_WRITE, 5'h0, 5'h10, 3'h0, 4'h1, 16'h0);
    x(OP_PTR_READ, 5'h12, 5'h0, 3'h0, 4'h2, 16'h0);
    c(lat, 16'h2);
    sd(5'h12, 16'h0120);
    c({mem_model_i.dmem[272], mem_model_i.dmem[288]}, 16'h3C04);
    li(5'h1E, 16'h0000);
    li(5'h1F, 16'h0001);
    x(OP_OFS_WRITE, 5'h0, 5'h11, 3'h0, 4'h8, 16'h0030);
    x(OP_PTR_WRITE, 5'h0, 5'h10, 3'h0, 4'h8, 16'h0);
    c({mem_model_i.dmem[304], mem_model_i.dmem[256]}, 16'h3C04);
    sd(5'h11, 16'h0025);
    c(lat, 16'h2);
    x(OP_PORT_IN, 5'h13, 5'h0, 3'h0, 4'h0, 16'h5);
    c(lat, 16'h1);
    sd(5'h13, 16'h0140);
    c(mem_model_i.dmem[320], 16'h003C);
    x(OP_CODE_READ, 5'h14, 5'h0, 3'h0, 4'h9, 16'h0);
    c(lat, 16'h3);
    x(OP_CODE_READ, 5'h15, 5'h0, 3'h0, 4'h8, 16'h0);
    sd(5'h14, 16'h0150);
    sd(5'h15, 16'h0151);
    c({mem_model_i.dmem[337], mem_model_i.dmem[336]}, 16'h7F80);
    x(OP_PUSH, 5'h0, 5'h11, 3'h0, 4'h0, 16'h0);
    c({sp_o[7:0], mem_model_i.dmem[255]}, 16'hFE3C);
    x(OP_POP, 5'h16, 5'h0, 3'h0, 4'h0, 16'h0);
    c(sp_o + lat, 16'h0101);
    x(OP_REG_COPY, 5'h00, 5'h11, 3'h0, 4'h0, 16'h0);
    x(OP_REG_COPY, 5'h01, 5'h10, 3'h0, 4'h0, 16'h0);
    x(OP_CODE_WRITE, 5'h0, 5'h0, 3'h0, 4'h8, 16'h0);
    c(mem_model_i.cmem[128], 16'h043C);
    complete_run();
  end
endmodule : bit_transfer_instr_exec_test
`default_nettype wire
